// ==== bench/tb_top.sv ====
/* Bench: framer and parser joined over the header link.
   Assumes the rtl files are compiled before it. */
`timescale 1ns/100ps
module tb_top;
  logic        clock, reset, seedWrite, start, padding, extension;
  logic        innerStart, haveInfo, payValid, payLast, payReady, busy;
  logic        hdrValid, rPad, rExt, rMark, rBest, rTwo, rErr, rPay;
  logic [1:0]  seedTuple, tuple, redundancy, rfGroupCountMinus1;
  logic [1:0]  rRed, rGrp;
  logic [15:0] seedValue, startOffset, rSeq, rOff;
  logic [6:0]  payloadType, rPt;
  logic [31:0] timeWord, rTime;
  logic [7:0]  payData, rData;
  logic [15:0] seqExp [4];
  logic [6:0]  kinds [4] = '{7'h51, 7'h52, 7'h61, 7'h10};
  int          fails, samples_checked;
  tunnel_hdr_if link ();
  tunnel_hdr_framer tunnel_hdr_framer_inst (.clock, .reset, .seedWrite,
    .seedTuple, .seedValue, .start, .tuple, .payloadType, .padding,
    .extension, .innerStart, .startOffset, .haveInfo, .timeWord,
    .redundancy, .rfGroupCountMinus1, .payValid, .payData, .payLast,
    .payReady, .busy, .link);
  tunnel_hdr_parser tunnel_hdr_parser_inst (.clock, .reset, .link,
    .hdrValid, .padding(rPad), .extension(rExt), .marker(rMark),
    .payloadType(rPt), .seqNumber(rSeq), .timeWord(rTime),
    .bestEffort(rBest), .redundancy(rRed), .rfGroupCountMinus1(rGrp),
    .twoPortGroups(rTwo), .startOffset(rOff), .hdrError(rErr),
    .payValid(rPay), .payData(rData));
  tunnel_hdr_properties tunnel_hdr_properties_inst (.clock, .reset,
    .valid(link.valid), .sop(link.sop), .data(link.data),
    .ready(link.ready));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Padding and extension follow the tuple bits to vary them cheaply
  task automatic send(logic [1:0] tu, logic [6:0] p, logic mk, hi,
                      logic [15:0] of, logic [31:0] t, logic [1:0] rd, gr);
    int n;
    logic got, st;
    logic [7:0] seen;
    got = 1'b0;
    seen = 8'h00;
    st = p == 7'h61;
    {tuple, payloadType, innerStart, haveInfo} <= {tu, p, mk, hi};
    {startOffset, timeWord, redundancy} <= {of, t, rd};
    {rfGroupCountMinus1, padding, extension} <= {gr, tu[0], tu[1]};
    {payData, payValid, payLast, start} <= {tu, p[5:0], 3'h7};
    @(posedge clock);
    start <= 1'b0;
    for (n = 0; n < 80 && !(got && !payValid && !busy); n++) begin
      @(posedge clock);
      if (payValid && payReady)
        payValid <= 1'b0;
      if (hdrValid)
        got = 1'b1;
      if (rPay)
        seen = rData;
    end
    if (n == 80) begin
      fails++;
      results;
    end else begin
      chk("seq", 32'(seqExp[tu]), 32'(rSeq));
      chk("type", 32'(p), 32'(rPt));
      chk("pad", 32'(tu[0]), 32'(rPad));
      chk("ext", 32'(tu[1]), 32'(rExt));
      chk("marker", 32'(mk), 32'(rMark));
      chk("offset", mk ? 32'(of) : 32'h0, 32'(rOff));
      chk("time", st || hi && p != 7'h10 ? t : 32'h0, rTime);
      chk("redund", st ? 32'(rd) : 32'h0, 32'(rRed));
      chk("groups", st ? 32'(gr) : 32'h0, 32'(rGrp));
      chk("two", 32'(st && gr == 2'h1), 32'(rTwo));
      chk("error", 32'h0, 32'(rErr));
      chk("payload", 32'(payData), 32'(seen));
      if (st)
        chk("best", 32'(t == 32'h0), 32'(rBest));
      seqExp[tu]++;
    end
  endtask
  initial begin
    {fails, samples_checked} = 64'h0;
    {seedWrite, start, padding, extension, innerStart, haveInfo} = 6'h0;
    {payValid, payLast, seedTuple, tuple, redundancy} = 8'h0;
    {rfGroupCountMinus1, seedValue, startOffset} = 34'h0;
    {payloadType, timeWord, payData} = 47'h0;
    seqExp = '{default: 16'h0000};
    reset = 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 4; i++)
      send(2'(i), kinds[i], !i[0], i != 1, {16{i[1]}},
           i == 2 ? 32'h0 : 32'hc0de0001 + 32'(i), 2'(i + 1),
           2'(i / 2));
    send(2'h0, 7'h61, 1'b0, 1'b0, 16'h0, 32'h00018000, 2'h0, 2'h0);
    seedWrite <= 1'b1;
    seedTuple <= 2'h3;
    seedValue <= 16'hffff;
    @(posedge clock);
    seedWrite <= 1'b0;
    seqExp[3] = 16'hffff;
    repeat (2)
      send(2'h3, 7'h51, 1'b1, 1'b1, 16'h0002, 32'h0000ffff, 2'h0,
           2'h0);
    results;
  end
endmodule

// ==== bench/tunnel_hdr_properties.sv ====
/* Checker on the header link between framer and parser.
   Assumes one clock; tb_top instantiates it beside the link. */
`include "tunnel_hdr_defs.svh"
`timescale 1ns/100ps
module tunnel_hdr_properties (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       valid,
  input wire logic       sop,
  input wire logic [7:0] data,
  input wire logic       ready
);
  logic [3:0] beat, cur;
  logic [6:0] pt;
  logic       mark;
  // Beat index in the header; parks at 12 so payload never matches
  assign cur = sop ? 4'h0 : beat;
  always_ff @(posedge clock) begin
    if (reset) begin
      beat <= 4'h0;
      pt   <= 7'h00;
      mark <= 1'b0;
    end else if (valid && ready) begin
      if (sop || (beat != 4'h0 && beat < 4'hc))
        beat <= cur + 4'h1;
      if (cur == 4'h1) begin
        pt   <= data[6:0];
        mark <= data[7];
      end
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);
  property p_ver; valid && sop |-> data[7:6] == `HDR_VERSION; endproperty
  a_ver: assert property (p_ver) else $error("bad version");
  property p_cc; valid && sop |-> data[3:0] == `HDR_CC_ZERO; endproperty
  a_cc: assert property (p_cc) else $error("bad count");
  property p_run; valid && sop |=> (valid && !sop) [*8]; endproperty
  a_run: assert property (p_run) else $error("header broken");
  property p_rev; valid && cur == 4'h8 |-> data[7:6] == `HDR_PROTO_REV;
  endproperty
  a_rev: assert property (p_rev) else $error("bad revision");
  property p_resa; valid && cur == 4'h8 |-> data[1:0] == 2'h0 &&
    (pt == `PT_STUDIO_LINK || data[5:2] == 4'h0); endproperty
  a_resa: assert property (p_resa) else $error("reserved set");
  property p_resb; valid && cur == 4'h9 |-> data == 8'h00; endproperty
  a_resb: assert property (p_resb) else $error("reserved set");
  property p_off; valid && !mark && cur inside {4'ha, 4'hb} |->
    data == 8'h00; endproperty
  a_off: assert property (p_off) else $error("offset not zero");
  property p_time; valid && cur inside {[4'h4:4'h7]} && !(pt inside
    {`PT_DATA_SOURCE, `PT_LINK_LAYER, `PT_STUDIO_LINK}) |-> data == 8'h00;
  endproperty
  a_time: assert property (p_time) else $error("time not zero");
endmodule

// ==== rtl/tunnel_hdr_defs.svh ====
/*
  Header field codes, widths and fixed values of the tunnel packet header.
  Assumes inclusion by bare name from design files of this block.
*/
`ifndef TUNNEL_HDR_DEFS_SVH
`define TUNNEL_HDR_DEFS_SVH

`define HDR_BYTES        4'hc
`define HDR_VERSION      2'h2
`define HDR_CC_ZERO      4'h0
`define HDR_PROTO_REV    2'h1
`define PT_DATA_SOURCE   7'h51
`define PT_LINK_LAYER    7'h52
`define PT_STUDIO_LINK   7'h61
`define SEQ_RESET        16'h0000

`endif

// ==== rtl/tunnel_hdr_framer.sv ====
/*
  Encapsulator end: serialises the twelve byte header, then payload bytes.
  Assumes the user holds the header fields stable from start until done.
*/
//Behaviour
//- Version field sent first as binary 10
//- Padding bit passed through from user
//- Extension bit constant per stream, user-held
//- Contributor count always zero
//- Marker set when inner packet starts here
//- Payload type codes 81, 82, 97
//- Per-tuple sequence counter wraps at 65536
//- Counters seeded from loadable start value
//- Time word carries earliest inner schedule time
//- Time word zero without inner headers
//- Upper half: low 16 seconds bits
//- Lower half: 16-bit second fraction
//- Studio-link time word: latest delivery, zero best-effort
//- Protocol revision sent as binary 01
//- Studio-link redundancy count field
//- Studio-link channel group count minus one
//- Group count one means two port groups
//- Reserved zero bits; unknown type zero time
//- Start pointer counts bytes before first start
//- Receiver follows inner length fields onward; the parser only passes payload bytes out
//- No start: marker zero, pointer zero
`include "tunnel_hdr_defs.svh"
`timescale 1ns/100ps
module tunnel_hdr_framer #(
  parameter int TUPLES = 4,
  parameter int TW     = $clog2(TUPLES)
) (
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          seedWrite,
  input  wire logic [TW-1:0] seedTuple,
  input  wire logic [15:0]   seedValue,
  input  wire logic          start,
  input  wire logic [TW-1:0] tuple,
  input  wire logic [6:0]    payloadType,
  input  wire logic          padding,
  input  wire logic          extension,
  input  wire logic          innerStart,
  input  wire logic [15:0]   startOffset,
  input  wire logic          haveInfo,
  input  wire logic [31:0]   timeWord,
  input  wire logic [1:0]    redundancy,
  input  wire logic [1:0]    rfGroupCountMinus1,
  input  wire logic          payValid,
  input  wire logic [7:0]    payData,
  input  wire logic          payLast,
  output logic               payReady,
  output logic               busy,
  tunnel_hdr_if.encap        link
);
  typedef enum logic [1:0] {IDLE, HEAD, BODY} state_t;

  state_t        state;
  logic [3:0]    byteIdx;
  logic [95:0]   header;
  logic [15:0]   seqCount [TUPLES];
  logic [TW-1:0] curTuple;
  logic          load;
  logic          accept;
  logic          lastHead;
  logic          seqStep;
  logic [31:0]   next_time;
  logic [15:0]   next_tail;
  logic [15:0]   next_offset;
  logic          next_marker;
  logic [95:0]   next_header;

  // The output stage takes a byte only when the old one has gone or it
  // is empty; header and counters move with it, so a stall from the
  // far end neither drops nor repeats a header byte
  assign load     = link.ready || !link.valid;
  assign accept   = payValid && payReady;
  assign lastHead = (state == HEAD) && (byteIdx == `HDR_BYTES - 4'h1);
  assign seqStep  = (state == HEAD) && (byteIdx == 4'h0) && load;

  function automatic tunnel_hdr_pkg::tunnel_kind_t kindOf(
    input logic [6:0] pt);
    unique case (pt)
      `PT_DATA_SOURCE: kindOf = tunnel_hdr_pkg::KIND_DATA_SOURCE;
      `PT_LINK_LAYER:  kindOf = tunnel_hdr_pkg::KIND_LINK_LAYER;
      `PT_STUDIO_LINK: kindOf = tunnel_hdr_pkg::KIND_STUDIO_LINK;
      default:         kindOf = tunnel_hdr_pkg::KIND_OTHER;
    endcase
  endfunction

  // Whole header is fixed at the cycle start is taken
  always_comb begin
    next_marker = innerStart;
    unique case (kindOf(payloadType))
      tunnel_hdr_pkg::KIND_DATA_SOURCE,
      tunnel_hdr_pkg::KIND_LINK_LAYER: begin
        // Seconds in upper half, fraction in lower
        next_time = haveInfo ? timeWord : 32'h0;
        next_tail = {`HDR_PROTO_REV, 14'h0};
      end
      tunnel_hdr_pkg::KIND_STUDIO_LINK: begin
        next_time = timeWord;
        next_tail = {`HDR_PROTO_REV, redundancy, rfGroupCountMinus1,
                     10'h0};
      end
      tunnel_hdr_pkg::KIND_OTHER: begin
        next_time = 32'h0;
        next_tail = {`HDR_PROTO_REV, 14'h0};
      end
    endcase
    // A pointer without a marker is ignored downstream; send zero
    next_offset        = next_marker ? startOffset : 16'h0;
    next_header[95:94] = `HDR_VERSION;
    next_header[93]    = padding;
    next_header[92]    = extension;
    next_header[91:88] = `HDR_CC_ZERO;
    next_header[87]    = next_marker;
    next_header[86:80] = payloadType;
    next_header[79:64] = seqCount[tuple];
    next_header[63:32] = next_time;
    next_header[31:16] = next_tail;
    next_header[15:0]  = next_offset;
  end

  // One counter per tuple; a seed load beats a step in the same cycle
  for (genvar g = 0; g < TUPLES; g++) begin : gen_seq
    logic [15:0] counter;
    logic        loadSeed;
    logic        stepSeq;
    assign loadSeed    = seedWrite && (seedTuple == TW'(g));
    assign stepSeq     = seqStep && (curTuple == TW'(g));
    assign seqCount[g] = counter;
    always_ff @(posedge clock) begin
      if (reset)
        counter <= `SEQ_RESET;
      else if (loadSeed)
        counter <= seedValue;
      else if (stepSeq)
        counter <= counter + 16'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= IDLE;
    end else begin
      unique case (state)
        IDLE: if (start) begin
          state <= HEAD;
        end
        HEAD: if (load && lastHead) begin
          state <= BODY;
        end
        BODY: if (accept && payLast) begin
          state <= IDLE;
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Header bytes counted as they enter the output stage
  always_ff @(posedge clock) begin
    if (reset) begin
      byteIdx <= 4'h0;
    end else if (state == IDLE) begin
      byteIdx <= 4'h0;
    end else if (state == HEAD && load) begin
      byteIdx <= byteIdx + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      header <= 96'h0;
    end else if (state == IDLE && start) begin
      header <= next_header;
    end else if (state == HEAD && load) begin
      header <= {header[87:0], 8'h0};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      curTuple <= '0;
    end else if (state == IDLE && start) begin
      curTuple <= tuple;
    end
  end

  // Payload bytes reach the link only when the user handshake takes them
  always_ff @(posedge clock) begin
    if (reset) begin
      link.valid <= 1'b0;
      link.sop   <= 1'b0;
      link.data  <= 8'h0;
    end else if (load) begin
      link.valid <= (state == HEAD) || (state == BODY && accept);
      link.sop   <= (state == HEAD) && (byteIdx == 4'h0);
      link.data  <= (state == HEAD) ? header[95:88] : payData;
    end
  end

  // Ready is registered and so falls a cycle late; the last byte clears
  // it at once, so nothing is taken once the packet has ended
  always_ff @(posedge clock) begin
    if (reset) begin
      payReady <= 1'b0;
    end else begin
      payReady <= (state == BODY) && link.ready && !(accept && payLast);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != IDLE) || start;
    end
  end
endmodule

// ==== rtl/tunnel_hdr_if.sv ====
/*
  Byte stream carrying header and payload from encapsulator to decapsulator.
  Assumes both ends share one clock; sop marks the first header byte.
*/
`timescale 1ns/100ps
interface tunnel_hdr_if;
  logic       valid;
  logic       sop;
  logic [7:0] data;
  logic       ready;
  modport encap (output valid, output sop, output data, input ready);
  modport decap (input valid, input sop, input data, output ready);
endinterface

// ==== rtl/tunnel_hdr_parser.sv ====
/*
  Decapsulator end: collects the twelve header bytes and presents fields.
  Assumes the sender marks the first header byte with sop.
*/
`include "tunnel_hdr_defs.svh"
`timescale 1ns/100ps
module tunnel_hdr_parser (
  input  wire logic        clock,
  input  wire logic        reset,
  tunnel_hdr_if.decap      link,
  output logic             hdrValid,
  output logic             padding,
  output logic             extension,
  output logic             marker,
  output logic [6:0]       payloadType,
  output logic [15:0]      seqNumber,
  output logic [31:0]      timeWord,
  output logic             bestEffort,
  output logic [1:0]       redundancy,
  output logic [1:0]       rfGroupCountMinus1,
  output logic             twoPortGroups,
  output logic [15:0]      startOffset,
  output logic             hdrError,
  output logic             payValid,
  output logic [7:0]       payData
);
  logic [3:0]  count;
  logic        inHead;
  logic [87:0] shift;
  logic [95:0] full;
  assign full = {shift, link.data};

  always_ff @(posedge clock) begin
    if (reset) link.ready <= 1'b0;
    else       link.ready <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count  <= 4'h0;
      inHead <= 1'b0;
      shift  <= 88'h0;
    end else if (link.valid && link.ready) begin
      shift <= {shift[79:0], link.data};
      if (link.sop) begin
        inHead <= 1'b1;
        count  <= 4'h1;
      end else if (inHead) begin
        count <= count + 4'h1;
        if (count == `HDR_BYTES - 4'h1) inHead <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      hdrValid           <= 1'b0;
      padding            <= 1'b0;
      extension          <= 1'b0;
      marker             <= 1'b0;
      payloadType        <= 7'h0;
      seqNumber          <= 16'h0;
      timeWord           <= 32'h0;
      bestEffort         <= 1'b0;
      redundancy         <= 2'h0;
      rfGroupCountMinus1 <= 2'h0;
      twoPortGroups      <= 1'b0;
      startOffset        <= 16'h0;
      hdrError           <= 1'b0;
      payValid           <= 1'b0;
      payData            <= 8'h0;
    end else begin
      hdrValid <= 1'b0;
      payValid <= link.valid && link.ready && !inHead && !link.sop;
      payData  <= link.data;
      if (link.valid && link.ready && inHead &&
          count == `HDR_BYTES - 4'h1) begin
        hdrValid    <= 1'b1;
        padding     <= full[93];
        extension   <= full[92];
        marker      <= full[87];
        payloadType <= full[86:80];
        seqNumber   <= full[79:64];
        timeWord    <= full[63:32];
        bestEffort  <= (full[86:80] == `PT_STUDIO_LINK) &&
                       (full[63:32] == 32'h0);
        redundancy  <= full[29:28];
        rfGroupCountMinus1 <= full[27:26];
        twoPortGroups <= (full[27:26] == 2'h1);
        // Pointer is meaningless without the marker
        startOffset <= full[87] ? full[15:0] : 16'h0;
        hdrError <= (full[95:94] != `HDR_VERSION) ||
                    (full[91:88] != `HDR_CC_ZERO);
      end
    end
  end
endmodule

// ==== rtl/tunnel_hdr_pkg.sv ====
/*
  Types used by the encapsulator end (the framer) of the tunnel header link.
  Assumes tunnel_hdr_defs.svh is available for the field constants.
*/
package tunnel_hdr_pkg;
  typedef enum logic [1:0] {
    KIND_DATA_SOURCE,
    KIND_LINK_LAYER,
    KIND_STUDIO_LINK,
    KIND_OTHER
  } tunnel_kind_t;
endpackage
